// file: inc/exp_bus_pkg.sv
// constants and types shared by both ends of the expansion bus port
// assumes a single 250 MHz system clock on both ends
package exp_bus_pkg;
    localparam int DMA_CH_N        = 8;            // index 4 is the cascade hole
    localparam logic [7:0] DMA_CH_MASK = 8'hEF;    // channels 7-5, 3-0
    localparam int SLOT_N          = 6;
    localparam int REQ_N           = DMA_CH_N + SLOT_N;
    localparam logic [15:0] IRQ_MASK = 16'hFFFA;   // lines 15-3 and 1
    localparam logic [2:0]  REG_BE_NONE = 3'h0;
    localparam int REG_N           = 8;
    localparam logic [1:0] OWN_HOST  = 2'h0;
    localparam logic [1:0] OWN_EISA  = 2'h1;
    localparam logic [1:0] OWN_ISA   = 2'h2;
    localparam logic [1:0] OWN_DEV   = 2'h3;
    localparam logic [1:0] EOP_STOP  = 2'h0;
    localparam logic [1:0] EOP_TC    = 2'h1;
    localparam logic [1:0] EOP_CHAIN = 2'h2;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int REFRESH_NS      = 15000;
    localparam int CLK_NS          = 4;
    localparam int REFRESH_CYC     = REFRESH_NS / CLK_NS;
    localparam int REFRESH_LEN     = 4;
    typedef enum logic [1:0] {ARB_IDLE, ARB_DMA, ARB_SLOT, ARB_REFRESH} arb_state_t;
endpackage

// file: inc/exp_bus_if.sv
// wires between the peripheral chip end and the expansion bus party end
// refresh, eop and ready pins resolve here as wired-or; byte enables and data take the device value when it drives
`timescale 1ns/1ns
interface exp_bus_if;
    logic [7:0]  dma_req;
    logic [7:0]  dma_grant_out;
    logic [5:0]  slot_master_request_in;
    logic [5:0]  slot_master_grant_out;
    logic        refresh_dev_o, refresh_dev_oe, refresh_bus_o, refresh_bus_oe;
    logic        cmd_strobe;
    logic        eop_dev_o, eop_dev_oe, eop_bus_o, eop_bus_oe;
    logic [15:0] irq;
    logic [3:0]  be_dev_o;
    logic        be_dev_oe;
    logic [2:0]  be_bus_o;
    logic        be_bus_oe;
    logic        rdy_dev_o, rdy_dev_oe, rdy_bus_o, rdy_bus_oe;
    logic [7:0]  data_dev_o;
    logic        data_dev_oe;
    logic [7:0]  data_bus_o;
    logic        slave_access;
    logic        slave_write;
    logic        int_ack;
    logic        slave_select_out;
    logic [1:0]  owner_aen;
    logic        io_check;
    wire refresh_line = (refresh_dev_oe & refresh_dev_o) | (refresh_bus_oe & refresh_bus_o);
    wire end_of_process_line = (eop_dev_oe & eop_dev_o) | (eop_bus_oe & eop_bus_o);
    wire slave_ready_line = (rdy_dev_oe & rdy_dev_o) | (rdy_bus_oe & rdy_bus_o);
    wire [3:0] byte_enable_lines = be_dev_oe ? be_dev_o : {1'b0, be_bus_oe ? be_bus_o : 3'h0};
    wire [7:0] register_data_lines = data_dev_oe ? data_dev_o : data_bus_o;
    modport dev (input dma_req, slot_master_request_in, cmd_strobe, irq, slave_access,
        slave_write, int_ack, io_check, refresh_line, end_of_process_line,
        slave_ready_line, byte_enable_lines, register_data_lines,
        output dma_grant_out, slot_master_grant_out, refresh_dev_o, refresh_dev_oe,
        eop_dev_o, eop_dev_oe, be_dev_o, be_dev_oe, rdy_dev_o, rdy_dev_oe,
        data_dev_o, data_dev_oe, slave_select_out, owner_aen);
    modport bus (input dma_grant_out, slot_master_grant_out, slave_select_out, owner_aen,
        refresh_line, end_of_process_line, slave_ready_line, register_data_lines,
        output dma_req, slot_master_request_in, cmd_strobe, irq, slave_access,
        slave_write, int_ack, io_check, refresh_bus_o, refresh_bus_oe, eop_bus_o,
        eop_bus_oe, be_bus_o, be_bus_oe, rdy_bus_o, rdy_bus_oe, data_bus_o);
endinterface

// file: hw/periph_end.sv
// peripheral chip end: arbiter, dma grant, refresh, eop, slave register port
// assumes bus inputs arrive asynchronously; all are double-flopped first
// Operation
// - seven dma request inputs accepted
// - one dma grant per request channel
// - six slot master request inputs accepted
// - six slot master grants driven
// - refresh driven only in own refresh ownership
// - refresh is input during isa mastership
// - command strobe tristates data after read
// - eop mode one: slave stops dma
// - eop mode two: terminal count input
// - eop mode three: chain buffer expired output
// - interrupt inputs on lines 15-3,1
// - byte enables driven as dma master, inputs as slave
// - ready driven on slave register write
// - master samples ready, advances burst address
// - data driven only on slave read/ack
// - slave select asserted during slave access unless the device is dma/refresh master
// - address enable shows current bus owner
// - io check raises nmi when enabled
// - slave decodes cycles; master does dma/refresh
// - rotating priority within each request level
`timescale 1ns/1ns
module periph_end (
    input  wire logic       sys_clk,        // system clock
    input  wire logic       rst,            // async reset, high
    exp_bus_if.dev          bus,            // expansion bus
    input  wire logic [1:0] eop_mode,       // end-of-process mode
    input  wire logic       chain_expired,  // chained buffer ran out
    input  wire logic       nmi_enable,     // io check may raise nmi
    input  wire logic       isa_master,     // isa adapter owns the bus
    output logic            nmi,            // non-maskable interrupt
    output logic [15:0]     irq_pending,    // synchronised interrupt lines
    output logic            dma_stop,       // eop stop or terminal count seen
    output logic [7:0]      burst_addr      // burst address pointer
);
    logic [7:0]  dreq_s1, dreq_s2;
    logic [5:0]  slot_master_request_in_s1, slot_master_request_in_s2;
    logic [15:0] irq_s1, irq_s2;
    logic [6:0]  misc_s1, misc_s2;
    logic [3:0]  be_s1, be_s2;
    logic [7:0]  dat_s1, dat_s2;
    logic [7:0]  regs [exp_bus_pkg::REG_N];
    exp_bus_pkg::arb_state_t state_q;
    logic [3:0]  owner_q;
    logic [3:0]  ptr_dma_q, ptr_slot_q;
    logic [15:0] ref_cnt_q;
    logic [2:0]  ref_len_q;
    logic        ref_pend_q;
    logic        rd_active_q;
    logic [7:0]  rd_data_q;
    logic        wr_ack_q;
    logic [7:0]  dreq_v;
    logic        found_dma, found_slot;
    logic [3:0]  pick_dma, pick_slot;
    logic [2:0]  reg_idx;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dreq_s1 <= 8'h00; dreq_s2 <= 8'h00;
            slot_master_request_in_s1 <= 6'h00; slot_master_request_in_s2 <= 6'h00;
            irq_s1 <= 16'h0000; irq_s2 <= 16'h0000;
            misc_s1 <= 7'h00; misc_s2 <= 7'h00;
            be_s1 <= 4'h0; be_s2 <= 4'h0;
            dat_s1 <= 8'h00; dat_s2 <= 8'h00;
        end else begin
            dreq_s1 <= bus.dma_req; dreq_s2 <= dreq_s1;
            slot_master_request_in_s1 <= bus.slot_master_request_in; slot_master_request_in_s2 <= slot_master_request_in_s1;
            irq_s1 <= bus.irq; irq_s2 <= irq_s1;
            misc_s1 <= {bus.int_ack, bus.cmd_strobe, bus.end_of_process_line,
                        bus.slave_ready_line, bus.slave_access, bus.slave_write,
                        bus.io_check};
            misc_s2 <= misc_s1;
            be_s1 <= bus.byte_enable_lines; be_s2 <= be_s1;
            dat_s1 <= bus.register_data_lines; dat_s2 <= dat_s1;
        end
    end

    wire ack_s = misc_s2[6];
    wire cmd_s = misc_s2[5];
    wire eop_s = misc_s2[4];
    wire rdy_s = misc_s2[3];
    wire acc_s = misc_s2[2];
    wire wr_s  = misc_s2[1];
    wire chk_s = misc_s2[0];

    assign irq_pending = irq_s2 & exp_bus_pkg::IRQ_MASK;
    assign dreq_v = dreq_s2 & exp_bus_pkg::DMA_CH_MASK;

    // rotating pick: search starts one past the last winner in each level
    always_comb begin
        found_dma = 1'b0; pick_dma = 4'h0;
        found_slot = 1'b0; pick_slot = 4'h0;
        for (int i = 1; i <= exp_bus_pkg::DMA_CH_N; i++) begin
            if (!found_dma && dreq_v[3'(ptr_dma_q + 4'(i))]) begin
                found_dma = 1'b1;
                pick_dma = 4'(3'(ptr_dma_q + 4'(i)));
            end
        end
        for (int i = 1; i <= exp_bus_pkg::SLOT_N; i++) begin
            if (!found_slot && slot_master_request_in_s2[(int'(ptr_slot_q) + i) % exp_bus_pkg::SLOT_N]) begin
                found_slot = 1'b1;
                pick_slot = 4'((int'(ptr_slot_q) + i) % exp_bus_pkg::SLOT_N);
            end
        end
    end

    // refresh level outranks dma, dma outranks slot masters
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= exp_bus_pkg::ARB_IDLE;
            owner_q <= 4'h0;
            ptr_dma_q <= 4'h7;
            ptr_slot_q <= 4'h5;
            ref_len_q <= 3'h0;
        end else begin
            case (state_q)
                exp_bus_pkg::ARB_IDLE: begin
                    if (ref_pend_q && !isa_master) begin
                        state_q <= exp_bus_pkg::ARB_REFRESH;
                        ref_len_q <= 3'(exp_bus_pkg::REFRESH_LEN);
                    end else if (found_dma) begin
                        state_q <= exp_bus_pkg::ARB_DMA;
                        owner_q <= pick_dma;
                        ptr_dma_q <= pick_dma;
                    end else if (found_slot) begin
                        state_q <= exp_bus_pkg::ARB_SLOT;
                        owner_q <= pick_slot;
                        ptr_slot_q <= pick_slot;
                    end
                end
                exp_bus_pkg::ARB_DMA: begin
                    if (!dreq_v[owner_q[2:0]]) state_q <= exp_bus_pkg::ARB_IDLE;
                end
                exp_bus_pkg::ARB_SLOT: begin
                    if (!slot_master_request_in_s2[owner_q[2:0]]) state_q <= exp_bus_pkg::ARB_IDLE;
                end
                exp_bus_pkg::ARB_REFRESH: begin
                    if (ref_len_q == 3'h1) state_q <= exp_bus_pkg::ARB_IDLE;
                    ref_len_q <= ref_len_q - 3'h1;
                end
                default: state_q <= exp_bus_pkg::ARB_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ref_cnt_q <= 16'h0000;
            ref_pend_q <= 1'b0;
        end else begin
            if (ref_cnt_q == 16'(exp_bus_pkg::REFRESH_CYC - 1)) begin
                ref_cnt_q <= 16'h0000;
                ref_pend_q <= 1'b1;                      // set wins over service
            end else begin
                ref_cnt_q <= ref_cnt_q + 16'h0001;
                if (state_q == exp_bus_pkg::ARB_REFRESH) ref_pend_q <= 1'b0;
            end
        end
    end

    always_comb begin
        bus.dma_grant_out = 8'h00;
        bus.slot_master_grant_out = 6'h00;
        if (state_q == exp_bus_pkg::ARB_DMA)
            bus.dma_grant_out[owner_q[2:0]] = 1'b1;
        if (state_q == exp_bus_pkg::ARB_SLOT)
            bus.slot_master_grant_out[owner_q[2:0]] = 1'b1;
    end

    wire dev_master = (state_q == exp_bus_pkg::ARB_DMA) || (state_q == exp_bus_pkg::ARB_REFRESH);

    // refresh pin released whenever an isa adapter owns the bus
    assign bus.refresh_dev_oe = (state_q == exp_bus_pkg::ARB_REFRESH) && !isa_master;
    assign bus.refresh_dev_o  = 1'b1;
    assign bus.owner_aen = isa_master ? exp_bus_pkg::OWN_ISA :
                           (state_q == exp_bus_pkg::ARB_SLOT) ? exp_bus_pkg::OWN_EISA :
                           dev_master ? exp_bus_pkg::OWN_DEV : exp_bus_pkg::OWN_HOST;

    assign bus.eop_dev_oe = (eop_mode == exp_bus_pkg::EOP_CHAIN);
    assign bus.eop_dev_o  = chain_expired;
    assign dma_stop = (state_q == exp_bus_pkg::ARB_DMA) && eop_s &&
                      (eop_mode == exp_bus_pkg::EOP_STOP || eop_mode == exp_bus_pkg::EOP_TC);

    assign bus.be_dev_oe = (state_q == exp_bus_pkg::ARB_DMA);
    assign bus.be_dev_o  = 4'hF;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) burst_addr <= 8'h00;
        else if (state_q != exp_bus_pkg::ARB_DMA) burst_addr <= 8'h00;
        else if (rdy_s) burst_addr <= burst_addr + 8'h04;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) nmi <= 1'b0;
        else if (chk_s && nmi_enable) nmi <= 1'b1;
        else if (!nmi_enable) nmi <= 1'b0;
    end

    // slave port: byte enables 2-0 pick a register
    assign reg_idx = be_s2[2:0];
    wire slave_ok = acc_s && !dev_master;
    assign bus.slave_select_out = slave_ok;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < exp_bus_pkg::REG_N; i++) regs[i] <= exp_bus_pkg::REG_RESET;
            wr_ack_q <= 1'b0;
        end else begin
            wr_ack_q <= slave_ok && wr_s;
            if (slave_ok && wr_s && !wr_ack_q) regs[reg_idx] <= dat_s2;
        end
    end

    assign bus.rdy_dev_oe = wr_ack_q;
    assign bus.rdy_dev_o  = 1'b1;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_active_q <= 1'b0;
            rd_data_q <= 8'h00;
        end else begin
            if (slave_ok && !wr_s && !cmd_s) begin
                rd_active_q <= 1'b1;
                rd_data_q <= ack_s ? 8'h00 : regs[reg_idx];
            end else if (cmd_s || !slave_ok) begin
                rd_active_q <= 1'b0;
            end
        end
    end

    assign bus.data_dev_oe = rd_active_q && slave_ok;
    assign bus.data_dev_o  = rd_data_q;
endmodule

// file: hw/bus_party_end.sv
// expansion bus party end: masters, dma slaves and adapters
// assumes the peripheral end answers within a few clocks
`timescale 1ns/1ns
module bus_party_end (
    input  wire logic        sys_clk,       // system clock
    input  wire logic        rst,           // async reset, high
    exp_bus_if.bus           bus,           // expansion bus
    input  wire logic [7:0]  dma_want,      // dma channel wants bus
    input  wire logic [5:0]  slot_want,     // slot wants bus
    input  wire logic        isa_refresh,   // isa master drives refresh
    input  wire logic        eop_pulse,     // slave stop / terminal count
    input  wire logic [15:0] irq_in,        // interrupt sources
    input  wire logic        ioerr,         // io check error
    input  wire logic        acc_req,       // register access request
    input  wire logic        acc_write,     // 1 write, 0 read
    input  wire logic [2:0]  acc_be,        // register select
    input  wire logic [7:0]  acc_wdata,     // write data
    input  wire logic        burst_ready,   // ready for dma cycles
    output logic [7:0]       acc_rdata,     // read data captured
    output logic [7:0]       dma_granted,   // dma grants seen
    output logic [5:0]       slot_granted   // slot grants seen
);
    logic [7:0] dg_s1, dg_s2;
    logic [5:0] mg_s1, mg_s2;
    logic [7:0] d_s1, d_s2;
    logic       sel_s1, sel_s2, sel_s3;
    logic       wr_q1, wr_q2;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dg_s1 <= 8'h00; dg_s2 <= 8'h00;
            mg_s1 <= 6'h00; mg_s2 <= 6'h00;
            d_s1 <= 8'h00; d_s2 <= 8'h00;
            sel_s1 <= 1'b0; sel_s2 <= 1'b0; sel_s3 <= 1'b0;
            wr_q1 <= 1'b0; wr_q2 <= 1'b0;
        end else begin
            dg_s1 <= bus.dma_grant_out; dg_s2 <= dg_s1;
            mg_s1 <= bus.slot_master_grant_out; mg_s2 <= mg_s1;
            d_s1 <= bus.register_data_lines; d_s2 <= d_s1;
            sel_s1 <= bus.slave_select_out; sel_s2 <= sel_s1; sel_s3 <= sel_s2;
            wr_q1 <= acc_write; wr_q2 <= wr_q1;
        end
    end

    assign dma_granted  = dg_s2;
    assign slot_granted = mg_s2;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) acc_rdata <= 8'h00;
        // read data trails select by a cycle, and a write's data lingers two stages
        else if (sel_s2 && sel_s3 && !wr_q2) acc_rdata <= d_s2;
    end

    assign bus.dma_req = dma_want & exp_bus_pkg::DMA_CH_MASK;
    assign bus.slot_master_request_in = slot_want;
    assign bus.refresh_bus_oe = isa_refresh;
    assign bus.refresh_bus_o  = 1'b1;
    assign bus.eop_bus_oe = eop_pulse;
    assign bus.eop_bus_o  = 1'b1;
    assign bus.irq = irq_in;
    assign bus.io_check = ioerr;
    assign bus.slave_access = acc_req;
    assign bus.slave_write = acc_write;
    assign bus.int_ack = 1'b0;
    assign bus.cmd_strobe = !acc_req;
    assign bus.be_bus_oe = acc_req;
    assign bus.be_bus_o  = acc_be;
    assign bus.data_bus_o = acc_write ? acc_wdata : 8'h00;
    assign bus.rdy_bus_oe = |dg_s2 && burst_ready;
    assign bus.rdy_bus_o  = 1'b1;
endmodule

// file: testbench/exp_bus_monitor.sv
// checker for the wires joining the peripheral end and the bus party end
// assumes it sits beside the interface instance, every input by name
`timescale 1ns/1ns
module exp_bus_monitor (
    input wire logic       sys_clk,                // system clock
    input wire logic       rst,                    // async reset, high
    input wire logic [7:0] dma_req,                // dma requests
    input wire logic [7:0] dma_grant_out,          // dma grants
    input wire logic [5:0] slot_master_request_in, // slot requests
    input wire logic [5:0] slot_master_grant_out,  // slot grants
    input wire logic       refresh_dev_oe,         // device drives refresh
    input wire logic [1:0] owner_aen,              // bus owner
    input wire logic       slave_write,            // write access
    input wire logic       rdy_dev_oe,             // device drives ready
    input wire logic       data_dev_oe,            // device drives data
    input wire logic       slave_select_out,       // device selected
    input wire logic       cmd_strobe              // command strobe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_ONE_GRANT: assert property (
        $onehot0({dma_grant_out, slot_master_grant_out})) else $error("two grants at once");
    AST_DMA_HOLE: assert property (
        (dma_grant_out & ~exp_bus_pkg::DMA_CH_MASK) == 8'h00) else $error("grant on hole");
    // requests cross two sync stages, so a grant looks back two to four edges
    AST_DMA_CAUSE: assert property (
        (dma_grant_out & ~($past(dma_req, 2) | $past(dma_req, 3) | $past(dma_req, 4))) == 8'h00)
        else $error("dma grant without request");
    AST_SLOT_CAUSE: assert property (
        (slot_master_grant_out & ~($past(slot_master_request_in, 2)
        | $past(slot_master_request_in, 3) | $past(slot_master_request_in, 4))) == 6'h00)
        else $error("slot grant without request");
    AST_GRANT_HOLD: assert property (
        ($past(dma_grant_out) & ~dma_grant_out & $past(dma_req)) == 8'h00)
        else $error("grant dropped while requested");
    AST_REFRESH_OWN: assert property (
        refresh_dev_oe |-> owner_aen == exp_bus_pkg::OWN_DEV
        && {dma_grant_out, slot_master_grant_out} == 14'h0000) else $error("refresh not owner");
    AST_REFRESH_LEN: assert property (
        $rose(refresh_dev_oe) |-> refresh_dev_oe [*4] ##1 !refresh_dev_oe)
        else $error("refresh length wrong");
    AST_DATA_SELECT: assert property (
        data_dev_oe |-> slave_select_out) else $error("data driven unselected");
    AST_RDY_WRITE: assert property (
        rdy_dev_oe |-> $past(slave_write, 2) || $past(slave_write, 3) || $past(slave_write, 4))
        else $error("ready without write");
    AST_CMD_OFF: assert property (
        $rose(cmd_strobe) |-> ##[1:5] !data_dev_oe) else $error("data kept after command");
endmodule

// file: testbench/eisa_side_arbiter_dma_port_test.sv
// self-checking bench joining the peripheral end to the bus party end
// assumes the package and interface are compiled first
`timescale 1ns/1ns
module eisa_side_arbiter_dma_port_test;
    logic        sys_clk, rst, chain_expired, nmi_enable, isa_master, isa_refresh;
    logic        eop_pulse, ioerr, acc_req, acc_write, burst_ready, nmi, dma_stop;
    logic [1:0]  eop_mode;
    logic [2:0]  acc_be;
    logic [5:0]  slot_want, slot_granted;
    logic [7:0]  dma_want, acc_wdata, acc_rdata, dma_granted, burst_addr, last_burst, d;
    logic [7:0]  regv[8];
    logic [15:0] irq_in, irq_pending, r;
    logic [15:0] q_grant[$], q_rd[$], q_irq[$], q_nmi[$], q_stop[$];
    int          err_count, checks, refresh_cnt, c0, i;
    exp_bus_if bus_if ();
    periph_end periph_end_i (.sys_clk(sys_clk), .rst(rst), .bus(bus_if.dev),
        .eop_mode(eop_mode), .chain_expired(chain_expired), .nmi_enable(nmi_enable),
        .isa_master(isa_master), .nmi(nmi), .irq_pending(irq_pending), .dma_stop(dma_stop),
        .burst_addr(burst_addr));
    bus_party_end bus_party_end_i (.sys_clk(sys_clk), .rst(rst), .bus(bus_if.bus),
        .dma_want(dma_want), .slot_want(slot_want), .isa_refresh(isa_refresh),
        .eop_pulse(eop_pulse), .irq_in(irq_in), .ioerr(ioerr), .acc_req(acc_req),
        .acc_write(acc_write), .acc_be(acc_be), .acc_wdata(acc_wdata), .burst_ready(burst_ready),
        .acc_rdata(acc_rdata), .dma_granted(dma_granted), .slot_granted(slot_granted));
    exp_bus_monitor exp_bus_monitor_i (.sys_clk(sys_clk), .rst(rst), .dma_req(bus_if.dma_req),
        .dma_grant_out(bus_if.dma_grant_out),
        .slot_master_request_in(bus_if.slot_master_request_in),
        .slot_master_grant_out(bus_if.slot_master_grant_out), .owner_aen(bus_if.owner_aen),
        .refresh_dev_oe(bus_if.refresh_dev_oe), .slave_write(bus_if.slave_write),
        .rdy_dev_oe(bus_if.rdy_dev_oe), .data_dev_oe(bus_if.data_dev_oe),
        .slave_select_out(bus_if.slave_select_out), .cmd_strobe(bus_if.cmd_strobe));
    task automatic check_now(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (exp !== got) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // a result with no note against it is compared with a value it can never take
    task automatic pop_check(input string what, ref logic [15:0] q[$], input logic [15:0] got);
        check_now(what, (q.size() == 0) ? 16'hDEAD : q.pop_front(), got);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic timeout(input string what);
        err_count++;
        $display("[ERR] %s expected done seen timeout", what);
        print_verdict();
    endtask
    task automatic release_winner();
        int n;
        for (n = 0; n < 40 && {slot_granted, dma_granted} === 14'h0000; n++) @(posedge sys_clk);
        if (n == 40) timeout("grant");
        repeat (4) @(posedge sys_clk);
        dma_want  <= dma_want & ~dma_granted;
        slot_want <= slot_want & ~slot_granted;
        for (n = 0; n < 40 && {slot_granted, dma_granted} !== 14'h0000; n++) @(posedge sys_clk);
        if (n == 40) timeout("release");
    endtask
    task automatic reg_access(input logic wr, input logic [2:0] be, input logic [7:0] wd);
        int n;
        acc_req   <= 1'b1;
        acc_write <= wr;
        acc_be    <= be;
        acc_wdata <= wd;
        for (n = 0; n < 40 && (wr ? bus_if.slave_ready_line : bus_if.data_dev_oe) !== 1'b1; n++)
            @(posedge sys_clk);
        if (n == 40) timeout("slave access");
        repeat (3) @(posedge sys_clk);
        acc_req <= 1'b0;
        for (n = 0; n < 40 && bus_if.slave_select_out !== 1'b0; n++) @(posedge sys_clk);
        if (n == 40) timeout("deselect");
    endtask
    always @(dma_granted or slot_granted) if ({slot_granted, dma_granted} !== 14'h0000) begin
        pop_check("grant", q_grant, {2'h0, slot_granted, dma_granted});
    end
    always @(acc_rdata) if (!rst) pop_check("read data", q_rd, {8'h00, acc_rdata});
    always @(irq_pending) if (!rst) pop_check("irq", q_irq, irq_pending);
    always @(nmi) if (!rst) pop_check("nmi", q_nmi, {15'h0000, nmi});
    always @(dma_stop) if (!rst) pop_check("dma stop", q_stop, {15'h0000, dma_stop});
    always @(burst_addr) if (!rst) begin
        // pointer clears once dma is left: one step past FC wraps to zero
        if (bus_if.dma_grant_out === 8'h00) last_burst = 8'hFC;
        check_now("burst", {8'h00, last_burst + 8'h04}, {8'h00, burst_addr});
        last_burst = burst_addr;
    end
    always @(posedge bus_if.refresh_dev_oe) refresh_cnt++;
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        {rst, chain_expired, nmi_enable, isa_master, isa_refresh, eop_pulse} = 6'h01 << 5;
        {ioerr, acc_req, acc_write, burst_ready, eop_mode, acc_be} = 9'h000;
        {slot_want, dma_want, acc_wdata, irq_in, last_burst} = 46'h0;
        {err_count, checks, refresh_cnt} = 96'h0;
        void'($urandom(7));
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        for (i = 0; i < 14; i++) if (i != 4) begin
            q_grant.push_back(16'h0001 << i);
            {slot_want, dma_want} <= 14'h0001 << i;
            release_winner();
        end
        // priority rotates on from the last winner (2), so 3 goes before 0
        q_grant.push_back(16'h0004);
        dma_want <= 8'h04;
        release_winner();
        q_grant.push_back(16'h0008);
        q_grant.push_back(16'h0001);
        q_grant.push_back(16'h0002);
        q_grant.push_back(16'h0400);
        dma_want <= 8'h09;
        repeat (2) release_winner();
        dma_want  <= 8'h02;
        slot_want <= 6'h04;
        repeat (2) release_winner();
        for (i = 0; i < 8; i++) begin
            d = 8'($urandom());
            regv[i] = {1'b1, d[6:3], i[2:0]};
            reg_access(1'b1, i[2:0], regv[i]);
        end
        for (i = 0; i < 8; i++) begin
            q_rd.push_back({8'h00, regv[i]});
            reg_access(1'b0, i[2:0], 8'h00);
        end
        r = 16'($urandom());
        r[3] = 1'b1;
        for (i = 0; i < 2; i++) begin
            q_irq.push_back((i == 0 ? r : ~r) & exp_bus_pkg::IRQ_MASK);
            irq_in <= (i == 0) ? r : ~r;
            repeat (10) @(posedge sys_clk);
        end
        ioerr <= 1'b1;
        repeat (10) @(posedge sys_clk);
        q_nmi.push_back(16'h0001);
        nmi_enable <= 1'b1;
        repeat (10) @(posedge sys_clk);
        ioerr <= d[1];
        repeat (10) @(posedge sys_clk);
        q_nmi.push_back(16'h0000);
        nmi_enable <= 1'b0;
        repeat (10) @(posedge sys_clk);
        q_grant.push_back(16'h0001);
        dma_want <= 8'h01;
        repeat (10) @(posedge sys_clk);
        for (i = 0; i < 2; i++) begin
            eop_mode <= i[1:0];
            q_stop.push_back(16'h0001);
            q_stop.push_back(16'h0000);
            eop_pulse <= 1'b1;
            repeat (10) @(posedge sys_clk);
            eop_pulse <= 1'b0;
            repeat (10) @(posedge sys_clk);
        end
        eop_mode      <= exp_bus_pkg::EOP_CHAIN;
        d = 8'($urandom());
        chain_expired <= d[0];
        repeat (20) begin
            r = 16'($urandom());
            burst_ready <= r[0];
            @(posedge sys_clk);
        end
        check_now("eop line", {15'h0000, d[0]}, {15'h0000, bus_if.end_of_process_line});
        chain_expired <= ~d[0];
        burst_ready   <= 1'b0;
        @(posedge sys_clk);
        check_now("eop line", {15'h0000, ~d[0]}, {15'h0000, bus_if.end_of_process_line});
        release_winner();
        d = 8'($urandom());
        isa_master  <= 1'b1;
        isa_refresh <= d[2];
        eop_pulse   <= d[3];
        c0 = refresh_cnt;
        repeat (4000) @(posedge sys_clk);
        check_now("isa refresh", {15'h0000, d[2]}, {15'h0000, bus_if.refresh_line});
        check_now("own refresh", 16'h0000, 16'(refresh_cnt - c0));
        isa_master  <= 1'b0;
        isa_refresh <= 1'b0;
        eop_pulse   <= 1'b0;
        repeat (4000) @(posedge sys_clk);
        check_now("own refresh", 16'h0001, {15'h0000, refresh_cnt > c0});
        check_now("open notes", 16'h0000, 16'(q_grant.size() + q_rd.size() + q_irq.size()
            + q_nmi.size() + q_stop.size()));
        print_verdict();
    end
endmodule
